// ==== core/uhc_pkg.sv ====
package uhc_pkg;

	// ==========================================================================
	// Register table
	localparam int UHC_NUM_REGS = 27;
	localparam int UHC_SLOT_W   = 5;
	localparam int UHC_IDX_W    = 8;

	typedef logic [UHC_SLOT_W-1:0] uhc_slot_t;
	typedef logic [31:0]           uhc_word_t;

	// Slot numbers used by the logic itself.
	localparam uhc_slot_t UHC_SLOT_CAP_LENGTH   = 5'h00;
	localparam uhc_slot_t UHC_SLOT_STRUCT_PARAM = 5'h01;
	localparam uhc_slot_t UHC_SLOT_CAP_PARAM    = 5'h02;
	localparam uhc_slot_t UHC_SLOT_HOST_COMMAND = 5'h03;
	localparam uhc_slot_t UHC_SLOT_FRAME_INDEX  = 5'h06;
	localparam uhc_slot_t UHC_SLOT_FRAME_END    = 5'h0A;
	localparam uhc_slot_t UHC_SLOT_PART_ID      = 5'h0E;
	localparam uhc_slot_t UHC_SLOT_CHIP_CONFIG  = 5'h15;

	// Register index of every slot; the byte address is four times the index.
	localparam logic [UHC_IDX_W-1:0] UHC_REG_INDEX [UHC_NUM_REGS] = '{
		8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h28,
		8'h30, 8'h34, 8'h50, 8'h70, 8'h74, 8'h80, 8'h84, 8'h88, 8'h8C,
		8'h90, 8'h92, 8'h94, 8'h96, 8'h98, 8'h9A, 8'h9C, 8'hA0, 8'hA4
	};

	// ==========================================================================
	// Capability fields
	localparam logic [7:0]  UHC_CAP_LENGTH    = 8'h10;
	localparam logic [7:0]  UHC_REV_MAJOR     = 8'h01;
	localparam logic [7:0]  UHC_REV_MINOR     = 8'h00;
	localparam logic [15:0] UHC_IF_REVISION   = {UHC_REV_MAJOR, UHC_REV_MINOR};
	localparam logic [7:0]  UHC_CAP_RSVD      = 8'h00;
	localparam logic [3:0]  UHC_NUM_PORTS     = 4'h1;
	localparam logic [27:0] UHC_SPARAM_RSVD   = 28'h0000000;
	localparam uhc_word_t   UHC_CAP_WORD      = {UHC_IF_REVISION, UHC_CAP_RSVD, UHC_CAP_LENGTH};
	localparam uhc_word_t   UHC_SPARAM_WORD   = {UHC_SPARAM_RSVD, UHC_NUM_PORTS};
	localparam int          UHC_HC_RESET_BIT  = 1;

	// ==========================================================================
	// Reset values
	localparam uhc_word_t UHC_REG_RESET [UHC_NUM_REGS] = '{
		UHC_CAP_WORD, UHC_SPARAM_WORD, 32'h00000006, 32'h00080B00,
		32'h00001000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00000000, 32'h00000041, 32'h00000000,
		32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h0000001F, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00001FA0, 32'h00000000, 32'h00000000,
		32'h00000400, 32'h00000000, 32'h00000000
	};

	// Bits that software may change; all others keep their reset value.
	localparam uhc_word_t UHC_REG_WMASK [UHC_NUM_REGS] = '{
		32'h00000000, 32'h00000000, 32'h00000000, 32'hFFFFFFFD,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0000FFFF,
		32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
		32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF
	};

	// ==========================================================================
	// Bus encodings
	localparam logic [1:0] UHC_HTRANS_NONSEQ = 2'h2;
	localparam logic       UHC_HRESP_OKAY    = 1'h0;

endpackage

// ==== core/uhc_cap_regs.sv ====
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
// Contract
// [R1] The low byte of the word at offset zero reads a fixed 8'h10, the offset of the operational space.
// [R2] The upper half of the word at offset zero is a read-only BCD interface revision of 16'h0100.
// [R3] In the revision field the upper byte holds the major digits and the lower byte the minor digits.
// [R4] The structural word reads 4'h1 ports in bits 3:0 with zeros above, and bits 15:8 of the capability word read zero.
// [R5] After reset every register returns its listed reset value; the part identification word reads PART_ID, not its listed 32'h00000000.
// [R6] Writes to the read-only capability and structural words are ignored.
module uhc_cap_regs #(
	parameter logic [31:0] PART_ID = 32'h00A5_005A
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata
);

	// ==========================================================================
	// Address decode
	// The part identification value above is arbitrary.
	typedef struct packed {
		logic             hit;
		uhc_pkg::uhc_slot_t slot;
	} uhc_lookup_t;

	function automatic uhc_lookup_t findSlot(input logic [31:0] addr);
		uhc_lookup_t res;
		res.hit  = 1'b0;
		res.slot = '0;
		for (int i = 0; i < uhc_pkg::UHC_NUM_REGS; i++) begin
			if (addr == {22'h000000, uhc_pkg::UHC_REG_INDEX[i], 2'h0}) begin
				res.hit  = 1'b1;
				res.slot = uhc_pkg::uhc_slot_t'(i);
			end
		end
		return res;
	endfunction

	uhc_lookup_t        lookup;
	logic               accept;
	logic               wrPendFf;
	logic               rdPendFf;
	uhc_pkg::uhc_slot_t wrSlotFf;
	uhc_pkg::uhc_slot_t rdSlotFf;
	logic               rdHitFf;
	logic               softReset;
	logic               firstCycleFf;
	logic [31:0]        regFf [uhc_pkg::UHC_NUM_REGS];
	logic [31:0]        hrdataFf;
	logic [31:0]        nxt_hrdata;

	// The slave never inserts wait states, so hready is ours and only qualifies.
	assign lookup    = findSlot(haddr);
	assign accept    = hsel && hready && (htrans == uhc_pkg::UHC_HTRANS_NONSEQ);
	assign softReset = wrPendFf && (wrSlotFf == uhc_pkg::UHC_SLOT_HOST_COMMAND) &&
		hwdata[uhc_pkg::UHC_HC_RESET_BIT];

	// ==========================================================================
	// Data phase tracking
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPendFf <= 1'b0;
			rdPendFf <= 1'b0;
			wrSlotFf <= '0;
			rdSlotFf <= '0;
			rdHitFf  <= 1'b0;
		end else begin
			wrPendFf <= accept && hwrite && lookup.hit;
			rdPendFf <= accept && !hwrite;
			wrSlotFf <= lookup.slot;
			rdSlotFf <= lookup.slot;
			rdHitFf  <= lookup.hit;
		end
	end

	// ==========================================================================
	// Register storage
	// Read-only bits carry a zero write mask, so they keep their reset value.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < uhc_pkg::UHC_NUM_REGS; i++) begin
				regFf[i] <= uhc_pkg::UHC_REG_RESET[i]; // see [R5]
			end
		end else if (softReset) begin
			// The controller reset bit reloads every register and clears itself.
			for (int i = 0; i < uhc_pkg::UHC_NUM_REGS; i++) begin
				regFf[i] <= uhc_pkg::UHC_REG_RESET[i]; // see [R5]
			end
		end else if (wrPendFf) begin
			regFf[wrSlotFf] <= (hwdata & uhc_pkg::UHC_REG_WMASK[wrSlotFf]) |
				(uhc_pkg::UHC_REG_RESET[wrSlotFf] & ~uhc_pkg::UHC_REG_WMASK[wrSlotFf]); // see [R6]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			firstCycleFf <= 1'b1;
		end else begin
			firstCycleFf <= 1'b0;
		end
	end

	// ==========================================================================
	// Read path
	// A read right behind a write to the same word sees the new value, because the masked
	// hwdata is forwarded: the write lands only on the edge that samples the read data.
	always_comb begin
		nxt_hrdata = 32'h00000000;
		if (accept && !hwrite && lookup.hit) begin
			case (lookup.slot)
				uhc_pkg::UHC_SLOT_CAP_LENGTH: begin
					nxt_hrdata = uhc_pkg::UHC_CAP_WORD; // see [R1] see [R2] see [R3] see [R4]
				end
				uhc_pkg::UHC_SLOT_STRUCT_PARAM: begin
					nxt_hrdata = uhc_pkg::UHC_SPARAM_WORD; // see [R4]
				end
				uhc_pkg::UHC_SLOT_PART_ID: begin
					nxt_hrdata = PART_ID;
				end
				default: begin
					if (softReset) begin
						nxt_hrdata = uhc_pkg::UHC_REG_RESET[lookup.slot];
					end else if (wrPendFf && (wrSlotFf == lookup.slot)) begin
						nxt_hrdata = (hwdata & uhc_pkg::UHC_REG_WMASK[lookup.slot]) |
							(uhc_pkg::UHC_REG_RESET[lookup.slot] &
							~uhc_pkg::UHC_REG_WMASK[lookup.slot]);
					end else begin
						nxt_hrdata = regFf[lookup.slot];
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdataFf <= 32'h00000000;
		end else begin
			hrdataFf <= nxt_hrdata;
		end
	end

	// ==========================================================================
	// Bus response
	logic hreadyoutFf;
	logic hrespFf;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyoutFf <= 1'b1;
			hrespFf     <= uhc_pkg::UHC_HRESP_OKAY;
		end else begin
			hreadyoutFf <= 1'b1;
			hrespFf     <= uhc_pkg::UHC_HRESP_OKAY;
		end
	end

	assign hreadyout = hreadyoutFf;
	assign hresp     = hrespFf;
	assign hrdata    = hrdataFf;

	// ==========================================================================
	// Checks
	capLength_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R1]
		rdPendFf && rdHitFf && (rdSlotFf == uhc_pkg::UHC_SLOT_CAP_LENGTH) |->
		hrdata[7:0] == 8'h10)
		else $error("capability length reads wrong");

	ifRevision_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R2]
		rdPendFf && rdHitFf && (rdSlotFf == uhc_pkg::UHC_SLOT_CAP_LENGTH) |->
		hrdata[31:16] == 16'h0100)
		else $error("interface revision reads wrong");

	revDigits_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R3]
		rdPendFf && rdHitFf && (rdSlotFf == uhc_pkg::UHC_SLOT_CAP_LENGTH) |->
		(hrdata[31:24] == 8'h01) && (hrdata[23:16] == 8'h00))
		else $error("revision digits misplaced");

	portCount_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R4]
		rdPendFf && rdHitFf && (rdSlotFf == uhc_pkg::UHC_SLOT_STRUCT_PARAM) |->
		hrdata == 32'h00000001)
		else $error("structural word reads wrong");

	capReserved_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R4]
		rdPendFf && rdHitFf && (rdSlotFf == uhc_pkg::UHC_SLOT_CAP_LENGTH) |->
		hrdata[15:8] == 8'h00)
		else $error("capability reserved byte not zero");

	resetValues_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R5]
		firstCycleFf |-> (regFf[uhc_pkg::UHC_SLOT_HOST_COMMAND] == 32'h00080B00) &&
		(regFf[uhc_pkg::UHC_SLOT_FRAME_END] == 32'h00000041) &&
		(regFf[uhc_pkg::UHC_SLOT_CHIP_CONFIG] == 32'h00001FA0))
		else $error("register reset value wrong");

	softReload_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R5]
		softReset |=> (regFf[uhc_pkg::UHC_SLOT_HOST_COMMAND] == 32'h00080B00) &&
		(regFf[uhc_pkg::UHC_SLOT_FRAME_INDEX] == 32'h00000000))
		else $error("controller reset did not reload registers");

	roIgnore_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
		wrPendFf && (wrSlotFf == uhc_pkg::UHC_SLOT_STRUCT_PARAM) |=>
		regFf[uhc_pkg::UHC_SLOT_STRUCT_PARAM] == $past(regFf[uhc_pkg::UHC_SLOT_STRUCT_PARAM]))
		else $error("read-only word changed by a write");

	cmdStore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wrPendFf && !softReset && (wrSlotFf == uhc_pkg::UHC_SLOT_HOST_COMMAND) |=>
		regFf[uhc_pkg::UHC_SLOT_HOST_COMMAND] == ($past(hwdata) & 32'hFFFFFFFD))
		else $error("command write not stored");

	busOkay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hreadyout && (hresp == 1'b0))
		else $error("bus response not ready and okay");

	// The read bus is quiet outside a mapped read, so a stale word can never be taken.
	idleZero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(rdPendFf && rdHitFf) |-> hrdata == 32'h00000000)
		else $error("read data not zero outside a read");

	capParam_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
		rdPendFf && rdHitFf && (rdSlotFf == uhc_pkg::UHC_SLOT_CAP_PARAM) |->
		hrdata == 32'h00000006)
		else $error("capability parameter word reads wrong");

	capHeld_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
		(regFf[uhc_pkg::UHC_SLOT_CAP_LENGTH] == 32'h01000010) &&
		(regFf[uhc_pkg::UHC_SLOT_STRUCT_PARAM] == 32'h00000001))
		else $error("read-only capability storage changed");

	// Half-word registers keep their upper half at zero whatever software writes.
	halfWord_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rdPendFf && rdHitFf && (rdSlotFf >= 5'h12) |-> hrdata[31:16] == 16'h0000)
		else $error("half-word register upper bits not zero");

endmodule // uhc_cap_regs

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	// ==========================================================================
	// Signals
	localparam logic [31:0] TB_PART_ID = 32'h0000_5AA5; // Arbitrary value.
	logic        sys_clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire logic   hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        rdPend;
	logic [31:0] expQ [$];
	logic [31:0] wdat;
	logic [31:0] wmask;
	int          n_errors;
	int          n_checks;
	int          seed;

	// The single slave drives the bus ready.
	assign hready = hreadyout;

	always #2 sys_clk = ~sys_clk;

	uhc_cap_regs #(.PART_ID(TB_PART_ID)) dut (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata)
	);

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] addrOf(input int i);
		return {22'h000000, uhc_pkg::UHC_REG_INDEX[i], 2'h0};
	endfunction

	function automatic logic [31:0] resetOf(input int i);
		if (i == int'(uhc_pkg::UHC_SLOT_PART_ID)) return TB_PART_ID;
		return uhc_pkg::UHC_REG_RESET[i];
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single transfer; waits for ready in both phases, as long as it takes.
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		haddr  <= addr;
		hwrite <= wr;
		htrans <= uhc_pkg::UHC_HTRANS_NONSEQ;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= data;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
	endtask

	task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
		expQ.push_back(exp);
		xfer(1'b0, addr, $random(seed));
	endtask

	task automatic readAll();
		for (int i = 0; i < uhc_pkg::UHC_NUM_REGS; i++) rd(addrOf(i), resetOf(i));
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================================
	// Monitor
	// Read data is taken at the edge that ends the data phase, before flops update.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdPend = 1'b0;
		end else begin
			if (rdPend && hreadyout === 1'b1) begin
				if (expQ.size() == 0) chk("spare read", 32'h0, 32'hFFFFFFFF);
				else chk("hrdata", expQ.pop_front(), hrdata);
				chk("hresp", {31'h0, uhc_pkg::UHC_HRESP_OKAY}, {31'h0, hresp});
			end
			if (hreadyout === 1'b1)
				rdPend = hsel && htrans == uhc_pkg::UHC_HTRANS_NONSEQ && !hwrite;
		end
	end

	// ==========================================================================
	// Sequence
	initial begin
		#200000;
		n_errors++;
		finish_test();
	end

	initial begin
		seed = 31036;
		sys_clk = 1'b0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(32'h0, {8'h01, 8'h00, 8'h00, 8'h10});
		rd(32'h10, {28'h0, 4'h1});
		readAll();
		// Bit 1 of every word is cleared so that the command word never self-resets here.
		for (int i = 0; i < uhc_pkg::UHC_NUM_REGS; i++) begin
			wdat = $random(seed) & 32'hFFFF_FFFD;
			wmask = uhc_pkg::UHC_REG_WMASK[i];
			xfer(1'b1, addrOf(i), wdat);
			rd(addrOf(i), (wdat & wmask) | (resetOf(i) & ~wmask));
		end
		rd(32'h0, 32'h0100_0010);
		xfer(1'b1, addrOf(3), 32'h0000_0002);
		readAll();
		xfer(1'b1, 32'h0000_0030, $random(seed));
		rd(32'h0000_0030, 32'h0);
		rd(32'h8000_0000, 32'h0);
		xfer(1'b1, addrOf(10), 32'h0000_5A5A);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(addrOf(10), 32'h0000_0041);
		rd(addrOf(21), 32'h0000_1FA0);
		repeat (2) @(posedge sys_clk);
		if (expQ.size() != 0) chk("pending reads", 32'h0, 32'(expQ.size()));
		finish_test();
	end
endmodule // testbench
